/* design/dlpm_pkg.sv */
package dlpm_pkg;

   // APB register offsets
   localparam logic [7:0] DLPM_OFS_CTRL   = 8'h00;
   localparam logic [7:0] DLPM_OFS_STATUS = 8'h04;
   localparam logic [7:0] DLPM_OFS_IRQST  = 8'h08;
   localparam logic [7:0] DLPM_OFS_IRQMSK = 8'h0C;

   // Power control register fields
   localparam int DLPM_CTRL_W       = 9;
   localparam int DLPM_B_DEEP       = 0;
   localparam int DLPM_B_PDS        = 1;
   localparam int DLPM_B_REG_LP     = 2;
   localparam int DLPM_B_SLEEP_RET  = 3;
   localparam int DLPM_B_SEV_PEND   = 4;
   localparam int DLPM_B_RTC_EN     = 5;
   localparam int DLPM_B_SLOW_RC_EN = 6;
   localparam int DLPM_B_SLOW_XT_EN = 7;
   localparam int DLPM_B_WDG_KEY    = 8;
   localparam logic [DLPM_CTRL_W-1:0] DLPM_CTRL_RST = 9'h000;

   // Status register fields
   localparam int DLPM_B_STBY_FLAG = 0;
   localparam int DLPM_B_STATE_LO  = 4;
   localparam int DLPM_B_WDG_RUN   = 8;
   localparam int DLPM_B_SRC_HSI   = 9;

   // Interrupt event bits
   localparam int DLPM_EV_W       = 4;
   localparam int DLPM_EV_REFUSED = 0;
   localparam int DLPM_EV_STOPWK  = 1;
   localparam int DLPM_EV_STBYWK  = 2;
   localparam int DLPM_EV_CANCEL  = 3;
   localparam logic [DLPM_EV_W-1:0] DLPM_EV_RST = 4'h0;

   // Real-time-clock flag layout: alarm a, alarm b, wakeup, tamper, timestamp
   localparam int DLPM_RTC_W = 5;

   // Timing
   localparam int DLPM_CLK_NS        = 50;
   localparam int DLPM_HSI_START_NS  = 2000;
   localparam int DLPM_REG_WAKE_NS   = 5000;
   localparam int DLPM_STBY_RST_NS   = 1000;
   localparam int DLPM_TMR_W         = 12;
   localparam int DLPM_HSI_CYC  = (DLPM_HSI_START_NS + DLPM_CLK_NS - 1) / DLPM_CLK_NS;
   localparam int DLPM_REG_CYC  = (DLPM_REG_WAKE_NS + DLPM_CLK_NS - 1) / DLPM_CLK_NS;
   localparam int DLPM_RST_CYC  = (DLPM_STBY_RST_NS + DLPM_CLK_NS - 1) / DLPM_CLK_NS;

   typedef enum logic [2:0] {
      DLPM_RUN,
      DLPM_ENTRY,
      DLPM_STOP,
      DLPM_WAKE,
      DLPM_STANDBY,
      DLPM_STBY_RST
   } dlpm_state_t;

endpackage

/* design/dlpm_sync.sv */
module dlpm_sync import dlpm_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* design/dlpm_timer.sv */
module dlpm_timer import dlpm_pkg::*; #(
   parameter int W = DLPM_TMR_W
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              done
);

   logic [W-1:0] cnt_q;
   logic         run_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done  <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         run_q <= 1'b1;
         done  <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_q - W'(1);
         run_q <= (cnt_q > W'(1));
         done  <= (cnt_q <= W'(1));
      end else begin
         done  <= 1'b0;
      end
   end

endmodule

/* design/dlpm_ctrl.sv */
module dlpm_ctrl import dlpm_pkg::*; #(
   parameter int LINES = 16
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic      [31:0]           prdata,
   output logic                       pslverr,
   // Core requests
   input  wire logic                  wfi_req,
   input  wire logic                  wfe_req,
   input  wire logic                  isr_return,
   input  wire logic                  int_pending,
   input  wire logic                  evt_pending,
   input  wire logic                  flash_busy,
   input  wire logic                  wdg_hw_option,
   // Wake sources
   input  wire logic [LINES-1:0]      ext_line,
   input  wire logic [LINES-1:0]      line_int_mode,
   input  wire logic [LINES-1:0]      line_evt_mode,
   input  wire logic [LINES-1:0]      vector_enable,
   input  wire logic [LINES-1:0]      line_pending_flags,
   input  wire logic                  periph_pending,
   input  wire logic [DLPM_RTC_W-1:0] rtc_flags,
   input  wire logic                  wakeup_event,
   input  wire logic                  wkup_pin,
   // Power and clock controls
   output logic                       core_clk_stop,
   output logic                       pll_off,
   output logic                       fast_osc_int_off,
   output logic                       fast_osc_ext_off,
   output logic                       sysclk_sel_fast_int,
   output logic                       regulator_lp,
   output logic                       regulator_off,
   output logic                       core_power_off,
   output logic                       domain_reset,
   output logic                       core_resume,
   output logic                       wdg_running,
   output logic                       rtc_keep,
   output logic                       slow_rc_keep,
   output logic                       slow_crystal_keep,
   // Interrupt
   output logic                       irq
);

   // Synchronised pins
   logic [LINES-1:0] line_s;
   logic             wake_evt_s;
   logic             wkup_s;

   dlpm_sync #(.W(LINES + 2)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({ext_line, wakeup_event, wkup_pin}),
      .sync_out ({line_s, wake_evt_s, wkup_s})
   );

   // Registers
   dlpm_state_t             state_q, state_d;
   logic [DLPM_CTRL_W-1:0]  ctrl_q;
   logic [DLPM_EV_W-1:0]    irqst_q, irqmsk_q, ev;
   logic                    stby_flag_q;
   logic                    wdg_q;
   logic                    kind_evt_q;
   logic                    kind_sev_q;
   logic                    wkup_prev_q;

   // APB decode
   wire  setup    = psel & ~penable;
   wire  access   = psel & penable & pready;
   wire  wr       = access & pwrite;
   wire  hit_ctrl = (paddr == DLPM_OFS_CTRL);
   wire  hit_stat = (paddr == DLPM_OFS_STATUS);
   wire  hit_ist  = (paddr == DLPM_OFS_IRQST);
   wire  hit_msk  = (paddr == DLPM_OFS_IRQMSK);
   wire  mapped   = hit_ctrl | hit_stat | hit_ist | hit_msk;
   wire  wr_ctrl  = wr & hit_ctrl;
   wire  wr_stat  = wr & hit_stat;
   wire  wr_ist   = wr & hit_ist;
   wire  wr_msk   = wr & hit_msk;

   wire [31:0] status_word = {22'h000000, sysclk_sel_fast_int, wdg_q,
                              1'b0, state_q, 3'h0, stby_flag_q};
   wire [31:0] rd_word =
      hit_ctrl ? {{(32-DLPM_CTRL_W){1'b0}}, ctrl_q} :
      hit_stat ? status_word :
      hit_ist  ? {{(32-DLPM_EV_W){1'b0}}, irqst_q} :
      hit_msk  ? {{(32-DLPM_EV_W){1'b0}}, irqmsk_q} : 32'h00000000;

   // Control bits
   wire deep     = ctrl_q[DLPM_B_DEEP];
   wire pds      = ctrl_q[DLPM_B_PDS];
   wire reg_lp   = ctrl_q[DLPM_B_REG_LP];
   wire slp_ret  = ctrl_q[DLPM_B_SLEEP_RET];
   wire sev_pend = ctrl_q[DLPM_B_SEV_PEND];

   // Entry qualification
   wire any_flag  = (|line_pending_flags) | periph_pending | (|rtc_flags);
   wire instr_ok  = (wfi_req & ~int_pending) | (wfe_req & ~evt_pending);
   wire ret_ok    = isr_return & ~int_pending & slp_ret;
   wire entry_req = deep & (instr_ok | ret_ok);
   wire entry_go  = entry_req & ~any_flag;
   wire entry_bad = entry_req & any_flag;
   wire new_evt   = wfe_req & ~wfi_req & ~ret_ok;

   // Wake source selection for the mode in use or being entered
   wire use_evt = (state_q == DLPM_RUN) ? new_evt : kind_evt_q;
   wire use_sev = (state_q == DLPM_RUN) ? sev_pend : kind_sev_q;
   wire wake_int_en  = |(line_s & line_int_mode & vector_enable);
   wire wake_int_any = |(line_s & line_int_mode);
   wire wake_evt_any = (|(line_s & line_evt_mode)) | wake_evt_s;
   wire stop_wake =
      !use_evt ? wake_int_en :
      !use_sev ? wake_evt_any :
                 (wake_int_any | wake_evt_any);
   wire stby_wake = (wkup_s & ~wkup_prev_q) | (|rtc_flags);

   // Wake delay
   logic                  tmr_load;
   logic [DLPM_TMR_W-1:0] tmr_count;
   logic                  tmr_done;

   dlpm_timer #(.W(DLPM_TMR_W)) u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (tmr_load),
      .count   (tmr_count),
      .done    (tmr_done)
   );

   wire [DLPM_TMR_W-1:0] wake_cyc = reg_lp
      ? DLPM_TMR_W'(DLPM_HSI_CYC + DLPM_REG_CYC)
      : DLPM_TMR_W'(DLPM_HSI_CYC);

   // Sequencer
   always_comb begin
      state_d   = state_q;
      tmr_load  = 1'b0;
      tmr_count = wake_cyc;
      ev        = DLPM_EV_RST;
      case (state_q)
         DLPM_RUN: begin
            ev[DLPM_EV_REFUSED] = entry_bad;
            if (entry_go) begin
               state_d = DLPM_ENTRY;
            end
         end
         DLPM_ENTRY: begin
            if (!pds && stop_wake) begin
               state_d            = DLPM_RUN;
               ev[DLPM_EV_CANCEL] = 1'b1;
            end else if (any_flag) begin
               state_d             = DLPM_RUN;
               ev[DLPM_EV_REFUSED] = 1'b1;
            end else if (!flash_busy) begin
               state_d = pds ? DLPM_STANDBY : DLPM_STOP;
            end
         end
         DLPM_STOP: begin
            if (stop_wake) begin
               state_d  = DLPM_WAKE;
               tmr_load = 1'b1;
            end
         end
         DLPM_WAKE: begin
            if (tmr_done) begin
               state_d            = DLPM_RUN;
               ev[DLPM_EV_STOPWK] = 1'b1;
            end
         end
         DLPM_STANDBY: begin
            if (stby_wake) begin
               state_d   = DLPM_STBY_RST;
               tmr_load  = 1'b1;
               tmr_count = DLPM_TMR_W'(DLPM_RST_CYC);
            end
         end
         DLPM_STBY_RST: begin
            if (tmr_done) begin
               state_d            = DLPM_RUN;
               ev[DLPM_EV_STBYWK] = 1'b1;
            end
         end
         default: state_d = DLPM_RUN;
      endcase
   end

   wire stby_exit = (state_q == DLPM_STBY_RST) & tmr_done;
   wire in_stop   = (state_d == DLPM_STOP) | (state_d == DLPM_WAKE);
   wire in_stby   = (state_d == DLPM_STANDBY) | (state_d == DLPM_STBY_RST);
   wire osc_off   = (state_d == DLPM_STOP) | in_stby;
   wire resume_d  = (ev[DLPM_EV_STOPWK] | ev[DLPM_EV_CANCEL] | ev[DLPM_EV_STBYWK]);

   wire [DLPM_CTRL_W-1:0] ctrl_wr_d =
      {1'b0, pwdata[DLPM_CTRL_W-2:0]};
   wire [DLPM_EV_W-1:0] irqst_d = stby_exit
      ? ev
      : (irqst_q & ~(wr_ist ? pwdata[DLPM_EV_W-1:0] : DLPM_EV_RST)) | ev;
   wire [DLPM_EV_W-1:0] irqmsk_d = stby_exit
      ? DLPM_EV_RST
      : (wr_msk ? pwdata[DLPM_EV_W-1:0] : irqmsk_q);
   wire stby_flag_d = stby_exit |
      (stby_flag_q & ~(wr_stat & pwdata[DLPM_B_STBY_FLAG]));
   wire wdg_d = wdg_q | wdg_hw_option |
      (wr_ctrl & pwdata[DLPM_B_WDG_KEY]);

   // APB answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         prdata  <= setup ? rd_word : 32'h00000000;
         pslverr <= setup & ~mapped;
      end
   end

   // Power control register survives standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= DLPM_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_wr_d;
      end
   end

   // Sequencer and status state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= DLPM_RUN;
         irqst_q     <= DLPM_EV_RST;
         irqmsk_q    <= DLPM_EV_RST;
         stby_flag_q <= 1'b0;
         wdg_q       <= 1'b0;
         kind_evt_q  <= 1'b0;
         kind_sev_q  <= 1'b0;
         wkup_prev_q <= 1'b0;
         irq         <= 1'b0;
      end else begin
         state_q     <= state_d;
         irqst_q     <= irqst_d;
         irqmsk_q    <= irqmsk_d;
         stby_flag_q <= stby_flag_d;
         wdg_q       <= wdg_d;
         wkup_prev_q <= wkup_s;
         irq         <= |(irqst_d & irqmsk_d);
         if (state_q == DLPM_RUN && entry_go) begin
            kind_evt_q <= new_evt;
            kind_sev_q <= sev_pend;
         end
      end
   end

   // Power, clock and keep-alive outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_clk_stop       <= 1'b0;
         pll_off             <= 1'b0;
         fast_osc_int_off    <= 1'b0;
         fast_osc_ext_off    <= 1'b0;
         sysclk_sel_fast_int <= 1'b1;
         regulator_lp        <= 1'b0;
         regulator_off       <= 1'b0;
         core_power_off      <= 1'b0;
         domain_reset        <= 1'b0;
         core_resume         <= 1'b0;
         wdg_running         <= 1'b0;
         rtc_keep            <= 1'b0;
         slow_rc_keep        <= 1'b0;
         slow_crystal_keep   <= 1'b0;
      end else begin
         core_clk_stop       <= in_stop | in_stby;
         pll_off             <= osc_off;
         fast_osc_int_off    <= osc_off;
         fast_osc_ext_off    <= osc_off;
         regulator_lp        <= in_stop & reg_lp;
         regulator_off       <= in_stby;
         core_power_off      <= in_stby;
         domain_reset        <= in_stby;
         core_resume         <= resume_d;
         wdg_running         <= wdg_d;
         rtc_keep            <= ctrl_q[DLPM_B_RTC_EN];
         slow_rc_keep        <= ctrl_q[DLPM_B_SLOW_RC_EN];
         slow_crystal_keep   <= ctrl_q[DLPM_B_SLOW_XT_EN];
         if (state_q == DLPM_STOP && stop_wake) begin
            sysclk_sel_fast_int <= 1'b1;
         end else if (wr_ctrl) begin
            sysclk_sel_fast_int <= sysclk_sel_fast_int;
         end
      end
   end

endmodule

/* tb/dlpm_ctrl_assertions.sv */
module dlpm_ctrl_chk import dlpm_pkg::*; #(
   parameter int LINES = 16
) (
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // APB handshake
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pready,
   // Pending and wake inputs
   input wire logic                  flash_busy,
   input wire logic                  wkup_pin,
   input wire logic [LINES-1:0]      line_pending_flags,
   input wire logic                  periph_pending,
   input wire logic [DLPM_RTC_W-1:0] rtc_flags,
   // Power outputs
   input wire logic                  core_clk_stop,
   input wire logic                  pll_off,
   input wire logic                  fast_osc_int_off,
   input wire logic                  fast_osc_ext_off,
   input wire logic                  sysclk_sel_fast_int,
   input wire logic                  regulator_off,
   input wire logic                  core_power_off,
   input wire logic                  core_resume,
   input wire logic                  wdg_running
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence pend_held_s;
      (|line_pending_flags || periph_pending || |rtc_flags) [*3];
   endsequence
   sequence standby_wake_s;
      $rose(wkup_pin) && core_power_off;
   endsequence

   apb_ready_a: assert property (apb_setup_s |=> pready)
      else $error("ready missing after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   sysclk_src_a: assert property (sysclk_sel_fast_int)
      else $error("system clock not on fast internal oscillator");
   stop_group_a: assert property (pll_off |-> core_clk_stop && fast_osc_int_off
      && fast_osc_ext_off)
      else $error("pll off with clocks running");
   standby_power_a: assert property ($rose(core_power_off) |-> regulator_off && pll_off)
      else $error("standby without regulator and pll off");
   flash_hold_a: assert property (flash_busy && !core_clk_stop |=> !$rose(core_clk_stop))
      else $error("entry during flash programming");
   pend_refuse_a: assert property (pend_held_s |=> !$rose(core_clk_stop))
      else $error("entry with pending flag");
   resume_pulse_a: assert property (core_resume |=> !core_resume)
      else $error("resume longer than one cycle");
   standby_exit_a: assert property (standby_wake_s |-> ##[1:40] !core_power_off)
      else $error("standby not left after wake pin");
   wdg_keep_a: assert property (wdg_running |=> wdg_running)
      else $error("watchdog stopped");
endmodule

bind dlpm_ctrl dlpm_ctrl_chk #(.LINES(LINES)) u_dlpm_ctrl_chk (.pclk, .presetn, .psel, .penable,
   .pready, .flash_busy, .wkup_pin, .line_pending_flags, .periph_pending, .rtc_flags,
   .core_clk_stop, .pll_off, .fast_osc_int_off, .fast_osc_ext_off, .sysclk_sel_fast_int,
   .regulator_off, .core_power_off, .core_resume, .wdg_running);

/* tb/dlpm_wake_src.sv */
module dlpm_wake_src (
   // Clock
   input  wire logic        pclk,
   // Command from bench
   input  wire logic        fire,
   input  wire logic [1:0]  src,
   input  wire logic [3:0]  idx,
   input  wire logic        slow,
   // Core acknowledge
   input  wire logic        ack,
   // Wake sources
   output logic      [15:0] ext_line,
   output logic             wkup_pin,
   output logic             wakeup_event
);
   timeunit 1ns;
   timeprecision 1ps;

   // Raised off the clock edge, held until the core resumes
   initial begin
      {ext_line, wkup_pin, wakeup_event} = '0;
      forever begin
         @(posedge pclk iff fire);
         repeat (slow ? 7 : 0) @(posedge pclk);
         #13;
         case (src)
            2'd0: ext_line[idx] = 1'b1;
            2'd1: wkup_pin = 1'b1;
            default: wakeup_event = 1'b1;
         endcase
         @(posedge pclk iff ack);
         #13;
         {ext_line, wkup_pin, wakeup_event} = '0;
      end
   end
endmodule

/* tb/testbench.sv */
module testbench import dlpm_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed = 32'h1563567D;
   logic        wfi_req, wfe_req, isr_return, flash_busy, periph_pending;
   logic        int_pending, evt_pending, wdg_hw_option;
   logic [15:0] ext_line, line_int_mode, line_evt_mode, vector_enable, line_pending_flags;
   logic [4:0]  rtc_flags;
   logic        wakeup_event, wkup_pin, fire, slow;
   logic [3:0]  idx;
   logic [1:0]  src;
   logic        core_clk_stop, pll_off, fast_osc_int_off, fast_osc_ext_off, sysclk_sel_fast_int;
   logic        regulator_lp, regulator_off, core_power_off, domain_reset, core_resume;
   logic        wdg_running, rtc_keep, slow_rc_keep, slow_crystal_keep;
   int          mismatches = 0, comparisons = 0;
   // Stop cases: instruction, control word, line modes {int, evt, vector}, wake source
   int          kind [5] = '{0, 1, 1, 2, 1};
   logic [31:0] cbit [5] = '{32'h01, 32'h01, 32'h11, 32'h09, 32'h11};
   logic [2:0]  cfg  [5] = '{3'b101, 3'b010, 3'b100, 3'b101, 3'b000};
   logic [1:0]  wsrc [5] = '{2'd0, 2'd0, 2'd0, 2'd0, 2'd2};

   dlpm_ctrl u_dlpm_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .wfi_req, .wfe_req, .isr_return, .int_pending, .evt_pending,
      .flash_busy, .wdg_hw_option, .ext_line, .line_int_mode, .line_evt_mode,
      .vector_enable, .line_pending_flags, .periph_pending, .rtc_flags, .wakeup_event, .wkup_pin,
      .core_clk_stop, .pll_off, .fast_osc_int_off, .fast_osc_ext_off, .sysclk_sel_fast_int,
      .regulator_lp, .regulator_off, .core_power_off, .domain_reset, .core_resume, .wdg_running,
      .rtc_keep, .slow_rc_keep, .slow_crystal_keep, .irq);
   dlpm_wake_src u_dlpm_wake_src (.pclk, .fire, .src, .idx, .slow, .ack(core_resume), .ext_line,
      .wkup_pin, .wakeup_event);

   always #25 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int wake_min(input logic lp);
      return DLPM_HSI_CYC + (lp ? DLPM_REG_CYC : 0);
   endfunction
   function automatic logic [31:0] stat_exp(input logic sbf, input logic wdg);
      return (32'h1 << DLPM_B_SRC_HSI) | (32'(wdg) << DLPM_B_WDG_RUN) | 32'(sbf);
   endfunction

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      chk(n == 1, "ready late");
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q === e, "read data");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic pulse(input int k);
      @(posedge pclk);
      {wfi_req, wfe_req, isr_return} <= 3'b100 >> k;
      @(posedge pclk);
      {wfi_req, wfe_req, isr_return} <= 3'b000;
   endtask
   task automatic wait_stop(input logic v, output int n);
      n = 0;
      while (core_clk_stop !== v && n < 600) begin
         @(posedge pclk);
         n++;
      end
      chk(core_clk_stop === v, "stop level");
   endtask
   task automatic wake(input logic [1:0] s);
      @(posedge pclk);
      {fire, src, idx, slow} <= {1'b1, s, 5'(rnd())};
      @(posedge pclk);
      fire <= 1'b0;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      $display("unexpected %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      logic [31:0] c;
      int n;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, wfi_req, wfe_req, isr_return} = '0;
      {flash_busy, periph_pending, fire, slow, src, idx, rtc_flags} = '0;
      {int_pending, evt_pending, wdg_hw_option} = '0;
      {line_int_mode, line_evt_mode, vector_enable, line_pending_flags} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(DLPM_OFS_CTRL, 32'h0);
      rd(DLPM_OFS_STATUS, stat_exp(1'b0, 1'b0));
      rd(8'h10, 32'h0);
      chk(err === 1'b1, "no slave error");
      $display("test reset done");
      wr(DLPM_OFS_CTRL, 32'h1);
      for (int s = 0; s < 3; s++) begin
         wr(DLPM_OFS_IRQMSK, 32'(s != 2));
         c = rnd();
         line_pending_flags <= s == 0 ? 16'h1 << c[3:0] : 16'h0;
         periph_pending <= s == 1;
         rtc_flags <= s == 2 ? 5'h1 << (c % 5) : 5'h0;
         pulse(0);
         repeat (4) @(posedge pclk);
         chk(core_clk_stop === 1'b0 && irq === (s != 2), "entry not refused");
         rd(DLPM_OFS_IRQST, 32'h1);
         wr(DLPM_OFS_IRQST, 32'h1);
         {line_pending_flags, periph_pending, rtc_flags} <= '0;
         repeat (2) @(posedge pclk);
         chk(irq === 1'b0, "irq not cleared");
      end
      pulse(2);
      repeat (4) @(posedge pclk);
      chk(core_clk_stop === 1'b0, "return entry without sleep bit");
      {int_pending, evt_pending} <= 2'b11;
      pulse(0);
      pulse(1);
      repeat (4) @(posedge pclk);
      chk(core_clk_stop === 1'b0, "entry with core request pending");
      {int_pending, evt_pending} <= 2'b00;
      $display("test refusal done");
      for (int k = 0; k < 5; k++) begin
         wr(DLPM_OFS_CTRL, cbit[k] | (32'(k[0]) << DLPM_B_REG_LP));
         {line_int_mode, line_evt_mode} <= {{16{cfg[k][2]}}, {16{cfg[k][1]}}};
         vector_enable <= {16{cfg[k][0] && k != 0}};
         pulse(kind[k]);
         wait_stop(1'b1, n);
         chk(pll_off === 1'b1 && fast_osc_int_off === 1'b1, "osc");
         chk(fast_osc_ext_off === 1'b1, "osc");
         chk(regulator_lp === k[0] && core_power_off === 1'b0, "regulator mode");
         wake(wsrc[k]);
         if (k == 0) begin
            repeat (12) @(posedge pclk);
            chk(core_clk_stop === 1'b1, "woke with vector off");
            vector_enable <= '1;
         end
         wait_stop(1'b0, n);
         chk(n >= wake_min(k[0]) && n <= wake_min(k[0]) + 16, "wake latency");
         chk(sysclk_sel_fast_int === 1'b1, "clock source");
         $display("test stop %0d done", k);
      end
      wr(DLPM_OFS_IRQST, 32'hF);
      wr(DLPM_OFS_CTRL, 32'h1);
      {line_int_mode, vector_enable, flash_busy} <= {16'hFFFF, 16'hFFFF, 1'b1};
      pulse(0);
      repeat (8) @(posedge pclk);
      chk(core_clk_stop === 1'b0, "entry during flash write");
      wake(2'd0);
      repeat (16) @(posedge pclk);
      flash_busy <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(core_clk_stop === 1'b0, "entry not cancelled");
      rd(DLPM_OFS_IRQST, 32'h8);
      flash_busy <= 1'b1;
      pulse(0);
      repeat (8) @(posedge pclk);
      flash_busy <= 1'b0;
      wait_stop(1'b1, n);
      chk(n == 2, "entry not resumed after flash write");
      wake(2'd0);
      wait_stop(1'b0, n);
      $display("test cancel done");
      wr(DLPM_OFS_IRQMSK, 32'hF);
      wr(DLPM_OFS_CTRL, 32'h1E3);
      pulse(0);
      wait_stop(1'b1, n);
      repeat (2) @(posedge pclk);
      chk(core_power_off === 1'b1 && regulator_off === 1'b1 && pll_off === 1'b1, "power");
      chk(rtc_keep === 1'b1 && slow_rc_keep === 1'b1, "keep");
      chk(wdg_running === 1'b1, "watchdog stopped");
      chk(slow_crystal_keep === 1'b1, "slow crystal off");
      wake(2'd1);
      wait_stop(1'b0, n);
      rd(DLPM_OFS_CTRL, 32'hE3);
      rd(DLPM_OFS_STATUS, stat_exp(1'b1, 1'b1));
      rd(DLPM_OFS_IRQST, 32'h4);
      rd(DLPM_OFS_IRQMSK, 32'h0);
      wr(DLPM_OFS_STATUS, 32'h1);
      rd(DLPM_OFS_STATUS, stat_exp(1'b0, 1'b1));
      $display("test standby done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(wdg_running === 1'b0, "watchdog survived reset");
      presetn <= 1'b1;
      wdg_hw_option <= 1'b1;
      @(posedge pclk);
      wdg_hw_option <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(wdg_running === 1'b1, "watchdog option ignored");
      $display("test watchdog done");
      close_out();
   end
endmodule
